/* src/ccs_pkg.sv */
// Constants shared by the converter configuration and status bank.
// Assumes a single 20 MHz system clock drives every user of this package.
package ccs_pkg;

  // Register offsets.
  localparam logic [7:0] OFS_CONFIG   = 8'h01;
  localparam logic [7:0] OFS_FAULT    = 8'h02;
  localparam logic [7:0] OFS_IDENT    = 8'h03;
  localparam logic [7:0] OFS_SET_LOW  = 8'h04;
  localparam logic [7:0] OFS_SET_HIGH = 8'h05;

  // Reset values.
  localparam logic [7:0] RST_CONFIG   = 8'h20;
  localparam logic [7:0] RST_FAULT    = 8'h00;
  localparam logic [6:0] RST_SET_LOW  = 7'h3C;
  localparam logic [6:0] RST_SET_HIGH = 7'h42;
  localparam logic [7:0] READ_ZERO    = 8'h00;

  // Configuration and fault field positions.
  localparam int BIT_SPAN      = 6;
  localparam int BIT_OUT_EN    = 5;
  localparam int BIT_CLAMP     = 4;
  localparam int BIT_FORCED    = 3;
  localparam int BIT_RAMP_FIX  = 2;
  localparam int SLEW_MSB      = 1;
  localparam int SLEW_LSB      = 0;
  localparam int BIT_OVERHEAT  = 1;
  localparam int BIT_SUPPLY_BAD = 0;

  // Ramp speed codes.
  localparam logic [1:0] SLEW_1V0  = 2'h0;
  localparam logic [1:0] SLEW_2V5  = 2'h1;
  localparam logic [1:0] SLEW_5V0  = 2'h2;

  // Timing: one code step is 25 mV; rates are in mV per ms.
  localparam int CLK_PERIOD_NS = 50;
  localparam int STEP_MV       = 25;
  localparam int RATE0_MV_MS   = 1000;
  localparam int RATE1_MV_MS   = 2500;
  localparam int RATE2_MV_MS   = 5000;
  localparam int RATE3_MV_MS   = 10000;
  localparam int NS_PER_MS     = 1000000;
  localparam int STEP_CYC0 = STEP_MV * NS_PER_MS / RATE0_MV_MS / CLK_PERIOD_NS;
  localparam int STEP_CYC1 = STEP_MV * NS_PER_MS / RATE1_MV_MS / CLK_PERIOD_NS;
  localparam int STEP_CYC2 = STEP_MV * NS_PER_MS / RATE2_MV_MS / CLK_PERIOD_NS;
  localparam int STEP_CYC3 = STEP_MV * NS_PER_MS / RATE3_MV_MS / CLK_PERIOD_NS;

  // Output target in millivolts.
  localparam logic [12:0] BASE_LOW_MV  = 13'h0708;
  localparam logic [12:0] BASE_HIGH_MV = 13'h07E9;
  localparam logic [5:0]  STEP_MV_W    = 6'h19;

  typedef enum logic [2:0] {
    RAMP_IDLE = 3'b001,
    RAMP_UP   = 3'b010,
    RAMP_DOWN = 3'b100
  } ccs_ramp_state_type;

endpackage : ccs_pkg

/* src/ccs_sticky_flag.sv */
// One sticky fault flag, set by a live condition and cleared by a read.
// Assumes the condition input is already synchronous to clk_sys_i.
`timescale 1ns/1ps
module ccs_sticky_flag (
  // Clock and control
  input  wire logic clk_sys_i,
  input  wire logic ce_i,
  input  wire logic clear_i,
  // Event side
  input  wire logic cond_i,
  input  wire logic read_clear_i,
  // Flag
  output logic      flag_o
);

  logic next_flag;

  // A live condition always wins over the read clear.
  assign next_flag = cond_i | (flag_o & ~read_clear_i);

  always_ff @(posedge clk_sys_i) begin
    if (ce_i) begin
      if (clear_i) begin
        flag_o <= 1'b0;
      end else begin
        flag_o <= next_flag;
      end
    end
  end

endmodule : ccs_sticky_flag

/* src/ccs_ramp.sv */
// Steps the applied setpoint code toward its target at the chosen speed.
// Assumes the target and speed inputs come from registers in the same domain.
`timescale 1ns/1ps
module ccs_ramp (
  // Clock and control
  input  wire logic       clk_sys_i,
  input  wire logic       ce_i,
  input  wire logic       clear_i,
  // Target
  input  wire logic [6:0] target_i,
  input  wire logic [1:0] slew_i,
  // Applied code
  output logic [6:0]      code_o,
  output logic            active_o
);

  ccs_pkg::ccs_ramp_state_type state;
  logic [8:0]                  count;
  logic                        primed;
  logic [8:0]                  period_last;
  logic                        step_due;

  assign period_last =
    (slew_i == ccs_pkg::SLEW_1V0) ? 9'(ccs_pkg::STEP_CYC0 - 1) :
    (slew_i == ccs_pkg::SLEW_2V5) ? 9'(ccs_pkg::STEP_CYC1 - 1) :
    (slew_i == ccs_pkg::SLEW_5V0) ? 9'(ccs_pkg::STEP_CYC2 - 1) :
                                    9'(ccs_pkg::STEP_CYC3 - 1);
  assign step_due = (count >= period_last);
  assign active_o = (state != ccs_pkg::RAMP_IDLE);

  always_ff @(posedge clk_sys_i) begin
    if (ce_i) begin
      if (clear_i) begin
        state  <= ccs_pkg::RAMP_IDLE;
        count  <= 9'h000;
        primed <= 1'b0;
        code_o <= ccs_pkg::RST_SET_LOW;
      end else if (!primed) begin
        // The first target after reset is applied at once.
        primed <= 1'b1;
        code_o <= target_i;
      end else begin
        case (state)
          ccs_pkg::RAMP_IDLE: begin
            count <= 9'h000;
            if (target_i > code_o) begin
              state <= ccs_pkg::RAMP_UP;
            end else if (target_i < code_o) begin
              state <= ccs_pkg::RAMP_DOWN;
            end
          end
          ccs_pkg::RAMP_UP: begin
            if (target_i <= code_o) begin
              state <= ccs_pkg::RAMP_IDLE;
            end else if (step_due) begin
              count  <= 9'h000;
              code_o <= code_o + 7'h01;
            end else begin
              count <= count + 9'h001;
            end
          end
          ccs_pkg::RAMP_DOWN: begin
            if (target_i >= code_o) begin
              state <= ccs_pkg::RAMP_IDLE;
            end else if (step_due) begin
              count  <= 9'h000;
              code_o <= code_o - 7'h01;
            end else begin
              count <= count + 9'h001;
            end
          end
          default: begin
            state <= ccs_pkg::RAMP_IDLE;
          end
        endcase
      end
    end
  end

endmodule : ccs_ramp

/* src/ccs_config_status_regs.sv */
// Configuration and status register bank of a buck-boost regulator.
// Assumes a serial protocol engine in the same clock domain hands over
// whole register writes and reads as single-cycle strobes.
//
// Functional notes
// R1: Enable low or supply collapse resets registers.
// R2: Configuration at 0x01, reset 0x20, bit7 zero.
// R3: Bit 6 selects low or high span.
// R4: Bit 5 gates output, resets to one.
// R5: Bit 4 enables minimum frequency clamp.
// R6: Bit 3 forces fixed-frequency switching.
// R7: Bit 2 enables fixed switching during ramps.
// R8: Bits 1-0 select ramp speed.
// R9: Setpoint changes ramp at programmed speed.
// R10: Status at 0x02; read clears flags.
// R11: Overheat flag latches; clears only when gone.
// R12: Supply-bad flag latches; clears only when gone.
// R13: Identity at 0x03, maker code high nibble.
// R14: Identity holds major and minor revision.
// R15: Low setpoint at 0x04, reset 0x3C.
// R16: Target is base plus code times 25mV.
// R17: High setpoint at 0x05, reset 0x42.
// R18: Ramp option forces fixed switching while ramping.
// R19: Undefined offsets read as 00h.
// R20: Write commits at final acknowledge strobe.
// R21: Reserved and read-only fields ignore writes.
`timescale 1ns/1ps
module ccs_config_status_regs #(
  // Arbitrary identity values.
  parameter logic [3:0] MAKER_CODE = 4'hA,
  parameter logic [1:0] REV_MAJOR  = 2'h0,
  parameter logic [1:0] REV_MINOR  = 2'h0
) (
  // Clock, reset, clock enable
  input  wire logic        clk_sys_i,
  input  wire logic        reset_n_i,
  input  wire logic        ce_i,
  // Device pins and supply monitor
  input  wire logic        enable_pin_i,
  input  wire logic        supply_input_ok_i,
  input  wire logic        setpoint_select_pin_i,
  // Register write from the serial engine
  input  wire logic        wr_commit_i,
  input  wire logic [7:0]  wr_addr_i,
  input  wire logic [7:0]  wr_data_i,
  // Register read from the serial engine
  input  wire logic        rd_strobe_i,
  input  wire logic [7:0]  rd_addr_i,
  output logic [7:0]       rd_data_o,
  // Fault conditions
  input  wire logic        overheat_i,
  input  wire logic        supply_bad_i,
  // Regulator controls
  output logic             out_enable_o,
  output logic             span_high_o,
  output logic             min_freq_clamp_o,
  output logic             fixed_switching_o,
  output logic             ramp_active_o,
  output logic [6:0]       vout_code_o,
  output logic [12:0]      target_mv_o
);

  logic [6:0]  config_bits;
  logic [6:0]  set_low;
  logic [6:0]  set_high;
  logic        overheat_flag;
  logic        supply_bad_flag;
  logic        ramp_active;
  logic [6:0]  ramp_code;

  // R1 bank reset sources
  logic        bank_clear;
  assign bank_clear = ~reset_n_i | ~enable_pin_i | ~supply_input_ok_i;

  // R20 write commit decode
  logic        wr_config;
  logic        wr_set_low;
  logic        wr_set_high;
  assign wr_config   = wr_commit_i & (wr_addr_i == ccs_pkg::OFS_CONFIG);
  assign wr_set_low  = wr_commit_i & (wr_addr_i == ccs_pkg::OFS_SET_LOW);
  assign wr_set_high = wr_commit_i & (wr_addr_i == ccs_pkg::OFS_SET_HIGH);

  // R10 status read clears
  logic        rd_fault;
  assign rd_fault = rd_strobe_i & (rd_addr_i == ccs_pkg::OFS_FAULT);

  // Read views of each register.
  logic [7:0]  config_view;
  logic [7:0]  fault_view;
  logic [7:0]  ident_view;
  logic [7:0]  set_low_view;
  logic [7:0]  set_high_view;
  logic [7:0]  next_rd_data;

  // R2 bit 7 reads zero
  assign config_view   = {1'b0, config_bits};
  assign fault_view    = {6'h00, overheat_flag, supply_bad_flag};
  // R13 R14 fixed identity
  assign ident_view    = {MAKER_CODE, REV_MAJOR, REV_MINOR};
  assign set_low_view  = {1'b0, set_low};
  assign set_high_view = {1'b0, set_high};

  // R19 unmapped offsets read zero
  assign next_rd_data =
    (rd_addr_i == ccs_pkg::OFS_CONFIG)   ? config_view   :
    (rd_addr_i == ccs_pkg::OFS_FAULT)    ? fault_view    :
    (rd_addr_i == ccs_pkg::OFS_IDENT)    ? ident_view    :
    (rd_addr_i == ccs_pkg::OFS_SET_LOW)  ? set_low_view  :
    (rd_addr_i == ccs_pkg::OFS_SET_HIGH) ? set_high_view :
                                           ccs_pkg::READ_ZERO;

  always_ff @(posedge clk_sys_i) begin
    if (ce_i) begin
      if (bank_clear) begin
        rd_data_o <= ccs_pkg::READ_ZERO;
      end else if (rd_strobe_i) begin
        rd_data_o <= next_rd_data;
      end
    end
  end

  // R2 R21 configuration store, bit 7 dropped
  always_ff @(posedge clk_sys_i) begin
    if (ce_i) begin
      if (bank_clear) begin
        config_bits <= ccs_pkg::RST_CONFIG[6:0];
      end else if (wr_config) begin
        config_bits <= wr_data_i[6:0];
      end
    end
  end

  // R15 R17 setpoint stores
  always_ff @(posedge clk_sys_i) begin
    if (ce_i) begin
      if (bank_clear) begin
        set_low  <= ccs_pkg::RST_SET_LOW;
        set_high <= ccs_pkg::RST_SET_HIGH;
      end else begin
        if (wr_set_low) begin
          set_low <= wr_data_i[6:0];
        end
        if (wr_set_high) begin
          set_high <= wr_data_i[6:0];
        end
      end
    end
  end

  // R11 overheat sticky flag
  ccs_sticky_flag u_overheat (
    .clk_sys_i    (clk_sys_i),
    .ce_i         (ce_i),
    .clear_i      (bank_clear),
    .cond_i       (overheat_i),
    .read_clear_i (rd_fault),
    .flag_o       (overheat_flag)
  );

  // R12 supply-bad sticky flag
  ccs_sticky_flag u_supply_bad (
    .clk_sys_i    (clk_sys_i),
    .ce_i         (ce_i),
    .clear_i      (bank_clear),
    .cond_i       (supply_bad_i),
    .read_clear_i (rd_fault),
    .flag_o       (supply_bad_flag)
  );

  // R9 R8 ramp toward selected setpoint
  logic [6:0]  target_code;
  assign target_code = setpoint_select_pin_i ? set_high : set_low;

  ccs_ramp u_ramp (
    .clk_sys_i (clk_sys_i),
    .ce_i      (ce_i),
    .clear_i   (bank_clear),
    .target_i  (target_code),
    .slew_i    (config_bits[ccs_pkg::SLEW_MSB:ccs_pkg::SLEW_LSB]),
    .code_o    (ramp_code),
    .active_o  (ramp_active)
  );

  // R16 target voltage in millivolts
  logic [12:0] base_mv;
  logic [12:0] next_target_mv;
  assign base_mv = config_bits[ccs_pkg::BIT_SPAN] ? ccs_pkg::BASE_HIGH_MV
                                                  : ccs_pkg::BASE_LOW_MV;
  assign next_target_mv = base_mv + 13'(ramp_code) * 13'(ccs_pkg::STEP_MV_W);

  // R7 R18 fixed switching while ramping
  logic        next_fixed;
  assign next_fixed = config_bits[ccs_pkg::BIT_FORCED] |
                      (config_bits[ccs_pkg::BIT_RAMP_FIX] & ramp_active);

  // R3 R4 R5 R6 control outputs
  always_ff @(posedge clk_sys_i) begin
    if (ce_i) begin
      if (bank_clear) begin
        out_enable_o      <= ccs_pkg::RST_CONFIG[ccs_pkg::BIT_OUT_EN];
        span_high_o       <= ccs_pkg::RST_CONFIG[ccs_pkg::BIT_SPAN];
        min_freq_clamp_o  <= ccs_pkg::RST_CONFIG[ccs_pkg::BIT_CLAMP];
        fixed_switching_o <= ccs_pkg::RST_CONFIG[ccs_pkg::BIT_FORCED];
        ramp_active_o     <= 1'b0;
        vout_code_o       <= ccs_pkg::RST_SET_LOW;
        target_mv_o       <= ccs_pkg::BASE_LOW_MV;
      end else begin
        out_enable_o      <= config_bits[ccs_pkg::BIT_OUT_EN];
        span_high_o       <= config_bits[ccs_pkg::BIT_SPAN];
        min_freq_clamp_o  <= config_bits[ccs_pkg::BIT_CLAMP];
        fixed_switching_o <= next_fixed;
        ramp_active_o     <= ramp_active;
        vout_code_o       <= ramp_code;
        target_mv_o       <= next_target_mv;
      end
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_clear_seen;
    ce_i && bank_clear;
  endsequence

  sequence s_cfg_write;
    ce_i && !bank_clear && wr_config;
  endsequence

  sequence s_two_live;
    ce_i && !bank_clear ##1 ce_i && !bank_clear;
  endsequence

  a_bank_reset_defaults: assert property ( // R1
    s_clear_seen |=> config_bits == ccs_pkg::RST_CONFIG[6:0]
      && set_low == ccs_pkg::RST_SET_LOW && set_high == ccs_pkg::RST_SET_HIGH)
    else $error("bank not at defaults after clear");

  a_config_write_store: assert property ( // R20
    s_cfg_write |=> config_bits == $past(wr_data_i[6:0]))
    else $error("configuration write not committed");

  a_enable_output_follow: assert property ( // R4
    ce_i && !bank_clear ##1 ce_i && !bank_clear
      |=> out_enable_o == $past(config_bits[ccs_pkg::BIT_OUT_EN]))
    else $error("output enable does not follow its bit");

  a_reserved_bit_zero: assert property ( // R21
    ce_i && !bank_clear && rd_strobe_i && rd_addr_i == ccs_pkg::OFS_CONFIG
      |=> rd_data_o[7] == 1'b0)
    else $error("reserved configuration bit read nonzero");

  a_unmapped_read_zero: assert property ( // R19
    ce_i && !bank_clear && rd_strobe_i && rd_addr_i > ccs_pkg::OFS_SET_HIGH
      |=> rd_data_o == ccs_pkg::READ_ZERO)
    else $error("unmapped offset read nonzero");

  a_flag_held_active: assert property ( // R11
    ce_i && !bank_clear && overheat_i |=> overheat_flag)
    else $error("overheat flag not latched");

  a_flag_read_clear: assert property ( // R12
    ce_i && !bank_clear && rd_fault && !supply_bad_i |=> !supply_bad_flag)
    else $error("supply-bad flag not cleared by read");

  a_ident_read_value: assert property ( // R13
    ce_i && !bank_clear && rd_strobe_i && rd_addr_i == ccs_pkg::OFS_IDENT
      |=> rd_data_o == {MAKER_CODE, REV_MAJOR, REV_MINOR})
    else $error("identity read wrong");

  a_ramp_forces_fixed: assert property ( // R18
    ce_i && !bank_clear && ramp_active && config_bits[ccs_pkg::BIT_RAMP_FIX]
      |=> fixed_switching_o)
    else $error("fixed switching not forced during ramp");

  a_ramp_single_step: assert property ( // R9
    ce_i && !bank_clear ##1 ce_i && !bank_clear && $changed(ramp_code)
      && $past(ramp_active)
      |-> (ramp_code == $past(ramp_code) + 7'h01)
       || (ramp_code == $past(ramp_code) - 7'h01))
    else $error("setpoint stepped instead of ramping");

  a_overheat_read_clear: assert property ( // R11
    ce_i && !bank_clear && rd_fault && !overheat_i |=> !overheat_flag)
    else $error("overheat flag not cleared by read");

  a_supply_flag_latch: assert property ( // R12
    ce_i && !bank_clear && supply_bad_i |=> supply_bad_flag)
    else $error("supply-bad flag not latched");

  a_fault_reserved_zero: assert property ( // R10
    ce_i && !bank_clear && rd_fault |=> rd_data_o[7:2] == 6'h00)
    else $error("status reserved bits read nonzero");

  a_setpoint_low_store: assert property ( // R15
    ce_i && !bank_clear && wr_set_low
      |=> set_low == $past(wr_data_i[6:0]))
    else $error("low setpoint write not committed");

  a_setpoint_high_store: assert property ( // R17
    ce_i && !bank_clear && wr_set_high
      |=> set_high == $past(wr_data_i[6:0]))
    else $error("high setpoint write not committed");

  a_span_output_follow: assert property ( // R3
    s_two_live
      |=> span_high_o == $past(config_bits[ccs_pkg::BIT_SPAN]))
    else $error("span output does not follow its bit");

  a_clamp_output_follow: assert property ( // R5
    s_two_live
      |=> min_freq_clamp_o == $past(config_bits[ccs_pkg::BIT_CLAMP]))
    else $error("clamp output does not follow its bit");

endmodule : ccs_config_status_regs

/* testbench/ccs_host_model.sv */
// Stand-in for the serial engine that hands whole writes and reads over.
// Assumes the bench calls its tasks; requests change on falling edges.
`timescale 1ns/1ps
module ccs_host_model (
  // Clock
  input  wire logic       clk_sys_i,
  // Read data from the bank
  input  wire logic [7:0] rd_data_i,
  // Requests toward the bank
  output logic            wr_commit_o,
  output logic [7:0]      wr_addr_o,
  output logic [7:0]      wr_data_o,
  output logic            rd_strobe_o,
  output logic [7:0]      rd_addr_o
);
  initial begin
    wr_commit_o = 1'b0;
    wr_addr_o   = 8'h00;
    wr_data_o   = 8'h00;
    rd_strobe_o = 1'b0;
    rd_addr_o   = 8'h00;
  end

  // commit at acknowledge
  // One pulse stands for the falling edge of the final acknowledge.
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    wr_addr_o   = a;
    wr_data_o   = d;
    wr_commit_o = 1'b1;
    @(negedge clk_sys_i);
    wr_commit_o = 1'b0;
    // Released lines carry the inverse so a stale value never passes.
    wr_addr_o   = ~a;
    wr_data_o   = ~d;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys_i);
    rd_addr_o   = a;
    rd_strobe_o = 1'b1;
    @(negedge clk_sys_i);
    d           = rd_data_i;
    rd_strobe_o = 1'b0;
    rd_addr_o   = ~a;
  endtask : read_reg
endmodule : ccs_host_model

/* testbench/converter_config_status_regs_bench.sv */
// Self-checking bench of the converter configuration and status bank.
// Assumes the host model issues every register access; ce_i is held high.
`timescale 1ns/1ps
`define CHK(what, exp, got) begin checked++; if ((got) !== (exp)) begin \
  bad_count++; $display("[ERR] %s expected %h seen %h", what, exp, got); \
  end end
module converter_config_status_regs_bench;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] r;
    logic [3:0] c;
  } ccs_row_type;
  // Identity values are arbitrary.
  localparam logic [3:0] MAKER = 4'h5;
  localparam logic [7:0] IDENT = 8'h59;
  localparam logic [15:0] RD_ROWS [8] = '{16'h0120, 16'h0200, 16'h0359,
    16'h043C, 16'h0542, 16'h0000, 16'h0600, 16'hFF00};
  localparam ccs_row_type WR_ROWS [9] = '{
    '{8'h01, 8'hCB, 8'h4B, 4'b1001}, '{8'h02, 8'hFF, 8'h00, 4'b1001},
    '{8'h03, 8'hFF, IDENT, 4'b1001}, '{8'h01, 8'h30, 8'h30, 4'b0110},
    '{8'h01, 8'h18, 8'h18, 4'b0011}, '{8'h01, 8'h40, 8'h40, 4'b1000},
    '{8'h05, 8'hC2, 8'h42, 4'b1000}, '{8'h06, 8'hFF, 8'h00, 4'b1000},
    '{8'h01, 8'h20, 8'h20, 4'b0100}};
  localparam int PER [4] = '{500, 200, 100, 50};

  logic        clk_sys_i;
  logic        reset_n_i;
  logic        enable_pin_i;
  logic        supply_input_ok_i;
  logic        setpoint_select_pin_i;
  logic        overheat_i;
  logic        supply_bad_i;
  logic        wr_commit_i;
  logic [7:0]  wr_addr_i;
  logic [7:0]  wr_data_i;
  logic        rd_strobe_i;
  logic [7:0]  rd_addr_i;
  logic [7:0]  rd_data_o;
  logic        out_enable_o;
  logic        span_high_o;
  logic        min_freq_clamp_o;
  logic        fixed_switching_o;
  logic        ramp_active_o;
  logic [6:0]  vout_code_o;
  logic [12:0] target_mv_o;
  logic [7:0]  got;
  logic [6:0]  code;
  logic        seen_fix;
  int          bad_count;
  int          checked;
  int          n;

  ccs_config_status_regs #(.MAKER_CODE(MAKER), .REV_MAJOR(2'h2),
    .REV_MINOR(2'h1)) uut (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .ce_i(1'b1),
    .enable_pin_i(enable_pin_i), .supply_input_ok_i(supply_input_ok_i),
    .setpoint_select_pin_i(setpoint_select_pin_i),
    .wr_commit_i(wr_commit_i), .wr_addr_i(wr_addr_i),
    .wr_data_i(wr_data_i), .rd_strobe_i(rd_strobe_i),
    .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o),
    .overheat_i(overheat_i), .supply_bad_i(supply_bad_i),
    .out_enable_o(out_enable_o), .span_high_o(span_high_o),
    .min_freq_clamp_o(min_freq_clamp_o),
    .fixed_switching_o(fixed_switching_o),
    .ramp_active_o(ramp_active_o), .vout_code_o(vout_code_o),
    .target_mv_o(target_mv_o));

  ccs_host_model host (
    .clk_sys_i(clk_sys_i), .rd_data_i(rd_data_o),
    .wr_commit_o(wr_commit_i), .wr_addr_o(wr_addr_i),
    .wr_data_o(wr_data_i), .rd_strobe_o(rd_strobe_i),
    .rd_addr_o(rd_addr_i));

  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  task automatic wrap_up;
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  // Waits for the applied code; the time taken must match the ramp speed.
  task automatic wait_code(input logic [6:0] c, input int p, input int st);
    n = 0;
    seen_fix = 1'b0;
    while (vout_code_o !== c && n < st * p + 20) begin
      @(negedge clk_sys_i);
      n++;
      if (ramp_active_o === 1'b1 && fixed_switching_o === 1'b1) begin
        seen_fix = 1'b1;
      end
    end
    `CHK("ramp time", 1'b1, (n >= st * p - 2 && n <= st * p + 6))
    `CHK("ramp fixed", 1'b1, seen_fix)
    if (vout_code_o !== c) begin
      wrap_up();
    end
  endtask : wait_code

  initial begin
    bad_count = 0;
    checked = 0;
    reset_n_i = 1'b0;
    enable_pin_i = 1'b1;
    supply_input_ok_i = 1'b1;
    setpoint_select_pin_i = 1'b0;
    overheat_i = 1'b0;
    supply_bad_i = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    reset_n_i = 1'b1;
    @(negedge clk_sys_i);
    foreach (RD_ROWS[i]) begin
      host.read_reg(RD_ROWS[i][15:8], got);
      `CHK("reset read", RD_ROWS[i][7:0], got)
    end
    `CHK("reset enable", 1'b1, out_enable_o)
    $display("reset values done");
    foreach (WR_ROWS[i]) begin
      host.write_reg(WR_ROWS[i].a, WR_ROWS[i].d);
      host.read_reg(WR_ROWS[i].a, got);
      `CHK("readback", WR_ROWS[i].r, got)
      `CHK("controls", WR_ROWS[i].c, {span_high_o, out_enable_o,
        min_freq_clamp_o, fixed_switching_o})
    end
    $display("register table done");
    code = 7'h3C;
    for (int s = 0; s < 4; s++) begin
      host.write_reg(8'h01, 8'h24 | 8'(s));
      code = code + 7'h02;
      host.write_reg(8'h04, {1'b1, code});
      wait_code(code, PER[s], 2);
      repeat (2) @(negedge clk_sys_i);
      `CHK("target", 13'h0708 + 13'(code) * 13'h0019, target_mv_o)
      `CHK("fixed idle", 1'b0, fixed_switching_o)
      host.read_reg(8'h04, got);
      `CHK("setpoint", {1'b0, code}, got)
    end
    setpoint_select_pin_i = 1'b1;
    wait_code(7'h42, 50, 2);
    repeat (2) @(negedge clk_sys_i);
    `CHK("high target", 13'h0D7A, target_mv_o)
    host.write_reg(8'h01, 8'h63);
    repeat (2) @(negedge clk_sys_i);
    `CHK("span", 1'b1, span_high_o)
    `CHK("span target", 13'h0E5B, target_mv_o)
    $display("ramp done");
    overheat_i = 1'b1;
    @(negedge clk_sys_i);
    overheat_i = 1'b0;
    host.read_reg(8'h02, got);
    `CHK("overheat set", 8'h02, got)
    host.read_reg(8'h02, got);
    `CHK("overheat clear", 8'h00, got)
    supply_bad_i = 1'b1;
    @(negedge clk_sys_i);
    host.read_reg(8'h02, got);
    host.read_reg(8'h02, got);
    `CHK("bad held", 8'h01, got)
    supply_bad_i = 1'b0;
    host.read_reg(8'h02, got);
    `CHK("bad latched", 8'h01, got)
    host.read_reg(8'h02, got);
    `CHK("bad clear", 8'h00, got)
    $display("fault flags done");
    setpoint_select_pin_i = 1'b0;
    for (int k = 0; k < 3; k++) begin
      host.write_reg(8'h01, 8'h4B);
      host.write_reg(8'h04, 8'h11);
      @(negedge clk_sys_i);
      reset_n_i = (k != 0);
      enable_pin_i = (k != 1);
      supply_input_ok_i = (k != 2);
      @(negedge clk_sys_i);
      reset_n_i = 1'b1;
      enable_pin_i = 1'b1;
      supply_input_ok_i = 1'b1;
      @(negedge clk_sys_i);
      host.read_reg(8'h01, got);
      `CHK("clear config", 8'h20, got)
      host.read_reg(8'h04, got);
      `CHK("clear setpoint", 8'h3C, got)
      `CHK("clear code", 7'h3C, vout_code_o)
      `CHK("clear enable", 1'b1, out_enable_o)
    end
    $display("clear sources done");
    wrap_up();
  end
endmodule : converter_config_status_regs_bench
